/* rtl/token_host_ctrl.sv */
// host-side controller driving one port of a dual-port token semaphore unit
// Overview of operation
// - host frees every token it no longer needs
// - initialise by writing one to all flags
// - claim is write zero then read back
// - failed claim polls or withdraws with one
// - owner releases by writing one
module token_host_ctrl #(
    parameter int unsigned SETUP_CYCLES = token_host_pkg::SETUP_CYC,
    parameter int unsigned STROBE_CYCLES = token_host_pkg::STROBE_CYC
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_in,
    input wire logic [token_host_pkg::INDEX_W-1:0] cmd_index_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic granted_out,
    output logic [token_host_pkg::NUM_TOKENS-1:0] owned_out,
    output logic token_space_select_n_out,
    output logic write_n_out,
    output logic read_n_out,
    output logic [token_host_pkg::INDEX_W-1:0] token_index_out,
    output logic [token_host_pkg::DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [token_host_pkg::DATA_W-1:0] data_in
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_SETUP,
        ST_WR_STROBE,
        ST_GAP,
        ST_RD_STROBE,
        ST_DONE
    } state_t;

    state_t state;                                          // access sequencer
    state_t next_state;
    logic [token_host_pkg::CNT_W-1:0] cnt;                  // phase timer
    logic [token_host_pkg::CNT_W-1:0] next_cnt;
    token_host_pkg::cmd_t cmd;                              // command being served
    token_host_pkg::cmd_t next_cmd;
    logic [token_host_pkg::INDEX_W-1:0] idx;                // flag in use
    logic [token_host_pkg::INDEX_W-1:0] next_idx;
    logic next_cmd_ready;
    logic next_done;
    logic next_granted;
    logic next_sel_n;
    logic next_write_n;
    logic next_read_n;
    logic [token_host_pkg::DATA_W-1:0] next_data;
    logic next_oe;
    logic own_wr;                                           // update owned bit
    logic own_val;
    logic [token_host_pkg::NUM_TOKENS-1:0] owned;

    // value to put on the bus: the request bit in bit zero, rest don't-care but driven equal
    function automatic logic [token_host_pkg::DATA_W-1:0] req_word(input token_host_pkg::cmd_t c);
        logic bitv;
        bitv = (c == token_host_pkg::CMD_CLAIM) ? token_host_pkg::REQ_CLAIM
                                                : token_host_pkg::REQ_FREE;
        req_word = {token_host_pkg::DATA_W{bitv}};  // device only looks at bit zero
    endfunction

    // load value of the phase timer, never less than one cycle
    function automatic logic [token_host_pkg::CNT_W-1:0] phase(input int unsigned n);
        phase = (n == 0) ? token_host_pkg::CNT_ONE : n[token_host_pkg::CNT_W-1:0];
    endfunction

    // owned bits kept apart so user logic sees them from a register
    token_owned_mem #(
        .DEPTH(token_host_pkg::NUM_TOKENS),
        .AW(token_host_pkg::INDEX_W)
    ) u_owned (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(own_wr),
        .wr_addr_in(idx),
        .wr_data_in(own_val),
        .rd_data_out(owned)
    );

    // sequencer: write phase, then for claims a separate read phase
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cmd = cmd;
        next_idx = idx;
        next_cmd_ready = 1'b0;
        next_done = 1'b0;
        next_granted = granted_out;
        next_sel_n = 1'b1;
        next_write_n = 1'b1;
        next_read_n = 1'b1;
        next_data = data_out;
        next_oe = 1'b0;
        own_wr = 1'b0;
        own_val = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_cmd_ready = 1'b1;
                if (cmd_valid_in && cmd_ready_out) begin
                    next_cmd_ready = 1'b0;
                    next_cmd = token_host_pkg::cmd_t'(cmd_in);
                    // init walks every flag from zero, once per port
                    next_idx = (token_host_pkg::cmd_t'(cmd_in) == token_host_pkg::CMD_INIT)
                             ? token_host_pkg::INDEX_ZERO : cmd_index_in;
                    next_state = ST_WR_SETUP;
                    next_cnt = phase(SETUP_CYCLES);
                    next_granted = 1'b0;
                end
            end
            ST_WR_SETUP: begin
                next_sel_n = 1'b0;                       // low bits select the flag
                next_oe = 1'b1;
                next_data = req_word(cmd);
                next_cnt = cnt - token_host_pkg::CNT_ONE;
                if (cnt == token_host_pkg::CNT_ONE) begin
                    next_state = ST_WR_STROBE;
                    next_write_n = 1'b0;
                    next_cnt = phase(STROBE_CYCLES);
                end
            end
            ST_WR_STROBE: begin
                next_sel_n = 1'b0;
                next_oe = 1'b1;
                next_write_n = 1'b0;
                next_cnt = cnt - token_host_pkg::CNT_ONE;
                if (cnt == token_host_pkg::CNT_ONE) begin
                    next_write_n = 1'b1;
                    next_sel_n = 1'b1;                   // deselect ends the write
                    next_state = ST_GAP;
                    next_cnt = phase(SETUP_CYCLES);
                    if (cmd != token_host_pkg::CMD_CLAIM) begin
                        own_wr = 1'b1;                   // a one write gives up ownership
                        own_val = 1'b0;
                    end
                end
            end
            ST_GAP: begin
                // select and enable stay high here so the device relatches on read
                next_cnt = cnt - token_host_pkg::CNT_ONE;
                if (cnt == token_host_pkg::CNT_ONE) begin
                    if (cmd == token_host_pkg::CMD_CLAIM) begin
                        next_state = ST_RD_STROBE;       // read back after the write
                        next_sel_n = 1'b0;
                        next_read_n = 1'b0;
                        next_cnt = phase(STROBE_CYCLES);
                    end else if (cmd == token_host_pkg::CMD_INIT &&
                                 idx != token_host_pkg::INDEX_LAST) begin
                        next_idx = idx + 3'h1;           // all eight flags freed
                        next_state = ST_WR_SETUP;
                        next_cnt = phase(SETUP_CYCLES);
                    end else begin
                        next_state = ST_DONE;
                    end
                end
            end
            ST_RD_STROBE: begin
                next_sel_n = 1'b0;
                next_read_n = 1'b0;
                next_cnt = cnt - token_host_pkg::CNT_ONE;
                if (cnt == token_host_pkg::CNT_ONE) begin
                    next_sel_n = 1'b1;
                    next_read_n = 1'b1;
                    // zero read back means ownership; bit zero suffices, all bits equal
                    next_granted = (data_in[0] == token_host_pkg::REQ_CLAIM);
                    own_wr = 1'b1;
                    own_val = (data_in[0] == token_host_pkg::REQ_CLAIM);
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // a failed claim leaves the request pending; user withdraws or polls
                next_done = 1'b1;
                next_state = ST_IDLE;
                next_cmd_ready = 1'b1;
            end
        endcase
    end

    // registers; device flags get no reset from here, only by init writes
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            cnt <= token_host_pkg::CNT_ZERO;
            cmd <= token_host_pkg::CMD_INIT;
            idx <= token_host_pkg::INDEX_ZERO;
            cmd_ready_out <= 1'b0;
            done_out <= 1'b0;
            granted_out <= 1'b0;
            token_space_select_n_out <= 1'b1;
            write_n_out <= 1'b1;
            read_n_out <= 1'b1;
            data_out <= '1;
            data_oe_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cmd <= next_cmd;
            idx <= next_idx;
            cmd_ready_out <= next_cmd_ready;
            done_out <= next_done;
            granted_out <= next_granted;
            token_space_select_n_out <= next_sel_n;
            write_n_out <= next_write_n;
            read_n_out <= next_read_n;
            data_out <= next_data;
            data_oe_out <= next_oe;
        end
    end

    // index pins follow the registered flag number
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            token_index_out <= token_host_pkg::INDEX_ZERO;
        end else begin
            token_index_out <= next_idx;
        end
    end

    assign owned_out = owned;                            // register output of u_owned
endmodule

/* rtl/token_host_pkg.sv */
// shared constants for the token semaphore host controller
package token_host_pkg;
    localparam int unsigned NUM_TOKENS = 8;            // independent flags on the device
    localparam int unsigned INDEX_W = 3;               // low address bits that pick a flag
    localparam int unsigned DATA_W = 8;                // port data width
    localparam int unsigned TIME_SETUP_NS = 10;        // address setup before strobe
    localparam int unsigned TIME_STROBE_NS = 20;       // strobe low width
    localparam int unsigned CLK_PERIOD_NS = 5;         // ref_clk_in period
    localparam int unsigned SETUP_CYC = (TIME_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC = (TIME_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 4;                 // width of the phase counter
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [INDEX_W-1:0] INDEX_ZERO = 3'h0;
    localparam logic [INDEX_W-1:0] INDEX_LAST = 3'h7;
    localparam logic REQ_CLAIM = 1'b0;                 // written bit that asks for a token
    localparam logic REQ_FREE = 1'b1;                  // written bit that frees a token
    // commands accepted on the user side
    typedef enum logic [1:0] {
        CMD_CLAIM,
        CMD_RELEASE,
        CMD_WITHDRAW,
        CMD_INIT
    } cmd_t;
endpackage

/* rtl/token_owned_mem.sv */
// small register array remembering which tokens this host holds
module token_owned_mem #(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic wr_data_in,
    output logic [DEPTH-1:0] rd_data_out
);
    logic [DEPTH-1:0] bits;       // one owned bit per token
    logic [DEPTH-1:0] next_bits;

    // write one bit, all others keep their value
    always_comb begin
        next_bits = bits;
        if (wr_en_in) begin
            next_bits[wr_addr_in] = wr_data_in;
        end
    end

    // registered storage and registered read port
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bits <= '0;
            rd_data_out <= '0;
        end else begin
            bits <= next_bits;
            rd_data_out <= next_bits;
        end
    end
endmodule

/* test/tb_token_host_ctrl.sv */
// self-checking bench for the token host controller
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_token_host_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic valid = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic [2:0] idx = 3'h0;
    logic ready, done, granted, sel_n, wr_n, rd_n, oe;
    logic [2:0] dev_idx;
    logic [7:0] owned, wdata, rdata, lreq;
    logic owr = 1'b0; // other port's write strobe
    logic [2:0] oidx = 3'h0;
    logic obit = 1'b1;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    token_host_ctrl token_host_ctrl_inst (.ref_clk_in(clk), .nrst_in(nrst),
        .cmd_valid_in(valid), .cmd_in(cmd), .cmd_index_in(idx), .cmd_ready_out(ready),
        .done_out(done), .granted_out(granted), .owned_out(owned),
        .token_space_select_n_out(sel_n), .write_n_out(wr_n), .read_n_out(rd_n),
        .token_index_out(dev_idx), .data_out(wdata), .data_oe_out(oe), .data_in(rdata));
    token_flag_model token_flag_model_inst (.ref_clk_in(clk), .sel_n_in(sel_n),
        .write_n_in(wr_n), .read_n_in(rd_n), .index_in(dev_idx), .data_in(wdata),
        .other_wr_in(owr), .other_index_in(oidx), .other_bit_in(obit),
        .data_out(rdata), .left_req_out(lreq));
    initial forever #2.5 clk = ~clk;
    // cut a hang short well past the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one command: wait for ready, hand it over, wait for done
    task automatic run(input logic [1:0] c, input logic [2:0] i);
        int n;
        n = 0;
        @(negedge clk);
        while (ready !== 1'b1 && n < 200) begin @(negedge clk); n++; end
        @(posedge clk);
        valid <= 1'b1;
        cmd <= c;
        idx <= i;
        @(posedge clk);
        valid <= 1'b0;
        while (done !== 1'b1 && n < 400) begin @(negedge clk); n++; end
        `CHK(done, 1'b1)
    endtask
    // a write from the other port
    task automatic other_wr(input logic [2:0] i, input logic b);
        @(posedge clk);
        owr <= 1'b1;
        oidx <= i;
        obit <= b;
        @(posedge clk);
        owr <= 1'b0;
    endtask
    // both ports free every flag at start-up
    task automatic t_init();
        run(2'h3, 3'h0);
        for (int i = 0; i < 8; i++) other_wr(i[2:0], 1'b1);
        `CHK(lreq, 8'hff)
        `CHK(owned, 8'h00)
    endtask
    // claim and release the first and last flag
    task automatic t_edges();
        for (int i = 0; i < 8; i += 7) begin
            run(2'h0, i[2:0]);
            `CHK(granted, 1'b1)
            `CHK(owned[i], 1'b1)
            run(2'h1, i[2:0]);
            `CHK(owned[i], 1'b0)
            `CHK(lreq[i], 1'b1)
        end
    endtask
    // release passes a pending claim across; host then loses and withdraws
    task automatic t_pass();
        run(2'h0, 3'h3);
        other_wr(3'h3, 1'b0);
        run(2'h1, 3'h3);
        run(2'h0, 3'h3);
        `CHK(granted, 1'b0)
        run(2'h2, 3'h3);
        `CHK(lreq[3], 1'b1)
        other_wr(3'h3, 1'b1);
    endtask
    // the earlier claimer keeps the token; retry after it frees
    task automatic t_early();
        other_wr(3'h5, 1'b0);
        run(2'h0, 3'h5);
        `CHK(granted, 1'b0)
        `CHK(owned[5], 1'b0)
        other_wr(3'h5, 1'b1);
        run(2'h0, 3'h5);
        `CHK(granted, 1'b1)
        run(2'h1, 3'h5);
        // a held token must be cleared by a later init, not only by reset
        run(2'h0, 3'h6);
        `CHK(owned[6], 1'b1)
        run(2'h3, 3'h0);
        `CHK(owned, 8'h00)
        `CHK(lreq, 8'hff)
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_init();
        t_edges();
        t_pass();
        t_early();
        print_verdict();
    end
endmodule

/* test/token_host_ctrl_assertions.sv */
// checker on the ports of the token host controller
module token_host_ctrl_assertions (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_ready_out,
    input wire logic done_out,
    input wire logic token_space_select_n_out,
    input wire logic write_n_out,
    input wire logic read_n_out,
    input wire logic [token_host_pkg::INDEX_W-1:0] token_index_out,
    input wire logic [token_host_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // a command accepted by the controller
    sequence s_take;
        cmd_valid_in && cmd_ready_out;
    endsequence
    // write strobe held for the full strobe time, then lifted
    sequence s_strobe;
        !write_n_out [*4] ##1 write_n_out;
    endsequence
    a_take_gives_done: assert property (s_take |-> ##[2:120] done_out)
        else $error("command did not finish");
    a_done_one_cycle: assert property (done_out |=> !done_out)
        else $error("done longer than a cycle");
    a_take_drops_ready: assert property (s_take |=> !cmd_ready_out)
        else $error("ready stayed high after take");
    a_write_selects: assert property (!write_n_out |-> !token_space_select_n_out)
        else $error("write strobe without select");
    a_no_read_write: assert property (!(!write_n_out && !read_n_out))
        else $error("read and write strobes together");
    a_write_bit_spread: assert property (!write_n_out |-> data_oe_out &&
        (data_out == 8'h00 || data_out == 8'hff))
        else $error("write data not a clean request bit");
    a_read_no_drive: assert property (!read_n_out |-> !data_oe_out)
        else $error("host drives data while reading");
    a_strobe_width: assert property ($fell(write_n_out) |-> s_strobe)
        else $error("write strobe width wrong");
    a_index_steady: assert property (!token_space_select_n_out &&
        $past(!token_space_select_n_out) |-> $stable(token_index_out))
        else $error("index moved while selected");
endmodule

bind token_host_ctrl token_host_ctrl_assertions token_host_ctrl_assertions_inst (
    .ref_clk_in, .nrst_in, .cmd_valid_in, .cmd_ready_out, .done_out,
    .token_space_select_n_out, .write_n_out, .read_n_out, .token_index_out,
    .data_out, .data_oe_out);

/* test/token_sem_model.sv */
// behavioural two-port token semaphore facing the host controller
module token_flag_model (
    input wire logic ref_clk_in,
    input wire logic sel_n_in,
    input wire logic write_n_in,
    input wire logic read_n_in,
    input wire logic [2:0] index_in,
    input wire logic [7:0] data_in,
    input wire logic other_wr_in,
    input wire logic [2:0] other_index_in,
    input wire logic other_bit_in,
    output logic [7:0] data_out,
    output logic [7:0] left_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // stale requests at power-up, so the host must free them itself
    logic [7:0] right_req = 8'h00;
    logic [1:0] owner [8]; // 0 free, 1 host, 2 other; no memory gating
    logic held = 1'b0;
    logic rd_bit = 1'b0;
    initial begin
        left_req_out = 8'h00;
        foreach (owner[i]) owner[i] = 2'h1;
    end
    // latch writes, then settle ownership of every flag
    always @(posedge ref_clk_in) begin
        if (!sel_n_in && !write_n_in) left_req_out[index_in] = data_in[0];
        if (other_wr_in) right_req[other_index_in] = other_bit_in;
        for (int i = 0; i < 8; i++) begin
            // freeing hands the token to a pending side
            if (owner[i] == 2'h1 && left_req_out[i]) owner[i] = right_req[i] ? 2'h0 : 2'h2;
            if (owner[i] == 2'h2 && right_req[i]) owner[i] = left_req_out[i] ? 2'h0 : 2'h1;
            // one winner; same-cycle tie goes to the host
            if (owner[i] == 2'h0) owner[i] = !left_req_out[i] ? 2'h1 : {!right_req[i], 1'b0};
        end
        // read value frozen while select and enable stay low
        if (sel_n_in || read_n_in) held = 1'b0;
        else if (!held) begin
            held = 1'b1;
            rd_bit = (owner[index_in] != 2'h1);
        end
    end
    // bit spread over the bus; when idle the bus shows the inverse
    assign data_out = held ? {8{rd_bit}} : {8{~rd_bit}};
endmodule
